// ==== handler_state_pkg.sv ====
// Purpose: Constants and types for the system handler active-state register
// Assumes: Single 32-bit register reached over a plain strobe port
// Notes: Offset is a local choice; only the low half is modelled
package handler_state_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] state_reg_offset = 8'h00;
    localparam logic [31:0] state_reg_reset = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int bit_mem_fault = 0;
    localparam int bit_bus_fault = 1;
    localparam int bit_usage_fault = 3;
    localparam int bit_supervisor_call = 7;
    localparam int bit_debug_watch = 8;
    localparam int bit_pendable_service = 10;
    localparam int flag_count = 6;

    // Writable bits; everything else reads zero
    localparam logic [31:0] active_mask = 32'h0000_058b;

    // Exception entry/return event lines, one bit per flag
    typedef struct packed {
        logic pendable_service;
        logic debug_watch;
        logic supervisor_call;
        logic usage_fault;
        logic bus_fault;
        logic mem_fault;
    } handler_events_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : handler_state_pkg

// ==== active_flag.sv ====
// Purpose: One active-status flag with hardware and software update
// Assumes: Entry and return arrive as one-cycle pulses
// Notes: Entry beats return, and both beat a software write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module active_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_enter,
    input wire logic hw_return,
    input wire logic sw_write,
    input wire logic sw_value,
    output logic flag_r
);
    logic flag_nxt;

    // Entry sets, return clears, else software value
    assign flag_nxt = hw_enter ? 1'b1 :
                      hw_return ? 1'b0 :
                      sw_write ? sw_value : flag_r;

    // Flag store
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule : active_flag
`default_nettype wire

// ==== handler_state.sv ====
// Purpose: Active-state bits of the system handler control register
// Assumes: One clock, synchronous active-high reset, strobe register port
// Assumes: Entry and return events arrive as one-cycle pulses from the exception logic
// Notes: Read data valid exactly one cycle after the read strobe, zero otherwise
// Notes: Handler entry beats return, and return beats a software write
// Notes: The enable and pending half of the register lives elsewhere
`timescale 1ns/1ps
`default_nettype none
module handler_state (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire handler_state_pkg::handler_events_t enter_ev,
    input wire handler_state_pkg::handler_events_t return_ev,
    output handler_state_pkg::handler_events_t active
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Bus request and decode results
    handler_state_pkg::reg_req_t req;
    wire wr_hit;
    wire rd_hit;
    // Per-flag write values and hardware events
    wire [5:0] wvals;
    wire [5:0] hw_set;
    wire [5:0] hw_clr;
    // Flag image and read path
    logic [5:0] flags;
    wire [31:0] state_word;
    logic [31:0] rdata_nxt;

    // Strobe qualified by the register address; shared by both strobes
    function automatic logic reg_hit(input logic [7:0] a, input logic s);
        return s && (a == handler_state_pkg::state_reg_offset);
    endfunction : reg_hit

    // Request bundle and strobe decode
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign wr_hit = reg_hit(req.addr, req.wr);
    assign rd_hit = reg_hit(req.addr, req.rd);
    // Exception logic events bypass the bus, so software cannot mask them
    assign hw_set = enter_ev;
    assign hw_clr = return_ev;

    // Write values from the flag bit positions, pendable flag in the top slot
    assign wvals = {req.wdata[handler_state_pkg::bit_pendable_service],
                    req.wdata[handler_state_pkg::bit_debug_watch],
                    req.wdata[handler_state_pkg::bit_supervisor_call],
                    req.wdata[handler_state_pkg::bit_usage_fault],
                    req.wdata[handler_state_pkg::bit_bus_fault],
                    req.wdata[handler_state_pkg::bit_mem_fault]};

    // ------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------
    // One flag cell per active bit, indexed as the event struct
    genvar g;
    generate
        for (g = 0; g < handler_state_pkg::flag_count; g = g + 1) begin : g_flag
            active_flag u_flag (
                .clk(clk),
                .rst(rst),
                .hw_enter(hw_set[g]),
                .hw_return(hw_clr[g]),
                .sw_write(wr_hit),
                .sw_value(wvals[g]),
                .flag_r(flags[g])
            );
        end
    endgenerate

    // Reassemble register image; reserved bits tie to zero
    // Mask applied again so a slip in the concatenation cannot leak a reserved bit
    assign state_word = {21'h000000,
                         flags[5], 1'b0, flags[4], flags[3], 3'h0,
                         flags[2], 1'b0, flags[1], flags[0]}
                        & handler_state_pkg::active_mask;

    // Unmapped or idle reads return zero
    assign rdata_nxt = rd_hit ? state_word : 32'h0000_0000;

    // Registered read data and status copy
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
            active <= '0;
        end else begin
            rdata <= rdata_nxt;
            // Copy trails the flags by one edge; flags stay internal
            active <= flags;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Flag first, status copy one edge later; the copy lags on purpose
    sequence s_flag_then_copy(f, c);
        f ##1 c;
    endsequence

    // Cycles with no handler event, and writes that race none
    wire no_event;
    wire sw_only;
    assign no_event = (hw_set == 6'h00) && (hw_clr == 6'h00);
    assign sw_only = wr_hit && no_event;

    // Reserved positions and idle cycles read zero
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (rdata & ~handler_state_pkg::active_mask) == 32'h0000_0000)
        else $error("reserved bit read nonzero");
    a_idle_read: assert property (@(posedge clk) disable iff (rst)
        !rd_hit |=> rdata == 32'h0000_0000)
        else $error("read data without a read");

    // Reset at one edge leaves flags and copy clear at the next
    a_reset_clear: assert property (@(posedge clk)
        rst |=> flags == 6'h00)
        else $error("flag not cleared by reset");
    a_reset_copy: assert property (@(posedge clk)
        rst |=> active == 6'h00)
        else $error("status copy not cleared by reset");

    // Entry sets a flag whatever software writes in the same cycle
    a_entry_sets: assert property (@(posedge clk) disable iff (rst)
        enter_ev.pendable_service |=> s_flag_then_copy(flags[5], active.pendable_service))
        else $error("entry did not set pendable flag");
    a_entry_debug: assert property (@(posedge clk) disable iff (rst)
        enter_ev.debug_watch |=> s_flag_then_copy(flags[4], active.debug_watch))
        else $error("entry did not set debug flag");
    a_entry_svc: assert property (@(posedge clk) disable iff (rst)
        enter_ev.supervisor_call |=> s_flag_then_copy(flags[3], active.supervisor_call))
        else $error("entry did not set supervisor flag");
    a_entry_usage: assert property (@(posedge clk) disable iff (rst)
        enter_ev.usage_fault |=> s_flag_then_copy(flags[2], active.usage_fault))
        else $error("entry did not set usage flag");
    a_entry_bus: assert property (@(posedge clk) disable iff (rst)
        enter_ev.bus_fault |=> s_flag_then_copy(flags[1], active.bus_fault))
        else $error("entry did not set bus fault flag");
    a_entry_mem: assert property (@(posedge clk) disable iff (rst)
        enter_ev.mem_fault |=> s_flag_then_copy(flags[0], active.mem_fault))
        else $error("entry did not set memory fault flag");

    // Return clears a flag unless entry meets it in the same cycle
    a_return_pend: assert property (@(posedge clk) disable iff (rst)
        (return_ev.pendable_service && !enter_ev.pendable_service) |=>
        s_flag_then_copy(!flags[5], !active.pendable_service))
        else $error("return did not clear pendable flag");
    a_return_debug: assert property (@(posedge clk) disable iff (rst)
        (return_ev.debug_watch && !enter_ev.debug_watch) |=> s_flag_then_copy(!flags[4], !active.debug_watch))
        else $error("return did not clear debug flag");
    a_return_svc: assert property (@(posedge clk) disable iff (rst)
        (return_ev.supervisor_call && !enter_ev.supervisor_call) |=>
        s_flag_then_copy(!flags[3], !active.supervisor_call))
        else $error("return did not clear supervisor flag");
    a_return_clears: assert property (@(posedge clk) disable iff (rst)
        (return_ev.usage_fault && !enter_ev.usage_fault) |=> s_flag_then_copy(!flags[2], !active.usage_fault))
        else $error("return did not clear usage flag");
    a_return_bus: assert property (@(posedge clk) disable iff (rst)
        (return_ev.bus_fault && !enter_ev.bus_fault) |=> s_flag_then_copy(!flags[1], !active.bus_fault))
        else $error("return did not clear bus fault flag");
    a_return_mem: assert property (@(posedge clk) disable iff (rst)
        (return_ev.mem_fault && !enter_ev.mem_fault) |=> s_flag_then_copy(!flags[0], !active.mem_fault))
        else $error("return did not clear memory fault flag");

    // A write with no handler event lands at the next edge
    a_pend_write: assert property (@(posedge clk) disable iff (rst)
        sw_only |=> flags[5] == $past(wdata[handler_state_pkg::bit_pendable_service]))
        else $error("pendable write lost");
    a_debug_write: assert property (@(posedge clk) disable iff (rst)
        sw_only |=> flags[4] == $past(wdata[handler_state_pkg::bit_debug_watch]))
        else $error("debug flag write lost");
    a_svc_write: assert property (@(posedge clk) disable iff (rst)
        sw_only |=> flags[3] == $past(wdata[handler_state_pkg::bit_supervisor_call]))
        else $error("supervisor write lost");
    a_usage_write: assert property (@(posedge clk) disable iff (rst)
        sw_only |=> flags[2] == $past(wdata[handler_state_pkg::bit_usage_fault]))
        else $error("usage write lost");
    a_bus_write: assert property (@(posedge clk) disable iff (rst)
        sw_only |=> flags[1] == $past(wdata[handler_state_pkg::bit_bus_fault]))
        else $error("bus fault write lost");
    a_mem_write: assert property (@(posedge clk) disable iff (rst)
        sw_only |=> flags[0] == $past(wdata[handler_state_pkg::bit_mem_fault]))
        else $error("memory fault write lost");

    // Read data show the flags as they stood at the strobe
    a_pend_read: assert property (@(posedge clk) disable iff (rst)
        rd_hit |=> rdata[handler_state_pkg::bit_pendable_service] == $past(flags[5]))
        else $error("pendable read wrong");
    a_debug_read: assert property (@(posedge clk) disable iff (rst)
        rd_hit |=> rdata[handler_state_pkg::bit_debug_watch] == $past(flags[4]))
        else $error("debug flag read wrong");
    a_svc_read: assert property (@(posedge clk) disable iff (rst)
        rd_hit |=> rdata[handler_state_pkg::bit_supervisor_call] == $past(flags[3]))
        else $error("supervisor read wrong");
    a_usage_read: assert property (@(posedge clk) disable iff (rst)
        rd_hit |=> rdata[handler_state_pkg::bit_usage_fault] == $past(flags[2]))
        else $error("usage read wrong");
    a_bus_read: assert property (@(posedge clk) disable iff (rst)
        rd_hit |=> rdata[handler_state_pkg::bit_bus_fault] == $past(flags[1]))
        else $error("bus fault read wrong");
    a_mem_read: assert property (@(posedge clk) disable iff (rst)
        rd_hit |=> rdata[handler_state_pkg::bit_mem_fault] == $past(flags[0]))
        else $error("memory fault read wrong");

    // Without events or writes the flags hold; the copy trails by one
    a_flags_hold: assert property (@(posedge clk) disable iff (rst)
        (!wr_hit && no_event) |=> flags == $past(flags))
        else $error("flag moved without cause");
    a_status_copy: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> active == $past(flags))
        else $error("status copy out of step");
endmodule : handler_state
`default_nettype wire

// ==== handler_state_tb_top.sv ====
// Purpose: Self-checking bench for the handler active-state register
// Assumes: Register at the package offset, read data one cycle after the strobe
// Notes: Expected values come from package field positions, package constants and fixed literals
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module handler_state_tb_top;
    // ------------------------------------------------------------
    // Stimulus signals and counters
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    handler_state_pkg::handler_events_t enter_ev = 6'h00;
    handler_state_pkg::handler_events_t return_ev = 6'h00;
    handler_state_pkg::handler_events_t active;
    int err_total = 0;
    int n_tests = 0;
    int pos [6] = '{handler_state_pkg::bit_mem_fault, handler_state_pkg::bit_bus_fault,
        handler_state_pkg::bit_usage_fault, handler_state_pkg::bit_supervisor_call,
        handler_state_pkg::bit_debug_watch, handler_state_pkg::bit_pendable_service};
    logic [31:0] got;
    logic [31:0] one;
    // 20 MHz clock
    always #25 clk = ~clk;
    handler_state DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .enter_ev(enter_ev), .return_ev(return_ev), .active(active));
    // ------------------------------------------------------------
    // Bus tasks; strobes last one cycle, one idle edge between calls
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata; // Sample after the answering edge has landed
    endtask : rd_reg
    // Event pulse, optionally racing a software write of the given word
    task automatic ev(input logic [5:0] e, input logic [5:0] r, input logic w, input logic [31:0] d);
        @(posedge clk);
        enter_ev <= e;
        return_ev <= r;
        addr <= handler_state_pkg::state_reg_offset;
        wdata <= d;
        wr <= w;
        @(posedge clk);
        enter_ev <= 6'h00;
        return_ev <= 6'h00;
        wr <= 1'b0;
    endtask : ev
    // Event struct order to register bit positions
    function automatic logic [31:0] ev2reg(input logic [5:0] e);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < 6; i++) v[pos[i]] = e[i];
        return v;
    endfunction : ev2reg
    task automatic test_done;
        if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // Watchdog: a hang counts as a mismatch
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        test_done();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("reset value", handler_state_pkg::state_reg_reset, got)
        `CHK("reset active", 6'h00, active)
        // All ones: only the flag bits stick
        wr_reg(handler_state_pkg::state_reg_offset, 32'hffff_ffff);
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("all ones", handler_state_pkg::active_mask, got)
        `CHK("active all", 6'h3f, active)
        // One flag at a time, reserved bits set as noise
        for (int i = 0; i < 6; i++) begin
            one = 32'h1 << pos[i];
            wr_reg(handler_state_pkg::state_reg_offset, one | ~handler_state_pkg::active_mask);
            rd_reg(handler_state_pkg::state_reg_offset, got);
            `CHK("single flag", one, got)
            `CHK("single active", 6'h01 << i, active)
        end
        // Read-modify-write keeps what was read
        rd_reg(handler_state_pkg::state_reg_offset, got);
        wr_reg(handler_state_pkg::state_reg_offset, got | 32'h0000_0001);
        // A stale answer would still show the word read just before
        #1;
        `CHK("idle rdata", 32'h0, rdata)
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("rmw", 32'h0000_0401, got)
        wr_reg(handler_state_pkg::state_reg_offset, 32'h0);
        // Unmapped address neither writes nor reads back
        wr_reg(8'h04, 32'hffff_ffff);
        rd_reg(8'h04, got);
        `CHK("unmapped read", 32'h0, got)
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("unmapped write", 32'h0, got)
        // Handler entry and return, one flag at a time for each flag
        for (int i = 0; i < 6; i++) begin
            ev(6'h01 << i, 6'h00, 1'b0, 32'h0000_0000);
            rd_reg(handler_state_pkg::state_reg_offset, got);
            `CHK("enter", ev2reg(6'h01 << i), got)
            ev(6'h00, 6'h01 << i, 1'b0, 32'h0000_0000);
            rd_reg(handler_state_pkg::state_reg_offset, got);
            `CHK("return", 32'h0, got)
        end
        // Entry beats a same-cycle software clear
        ev(6'h3f, 6'h00, 1'b1, 32'h0000_0000);
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("enter vs write", handler_state_pkg::active_mask, got)
        // Return beats a same-cycle software set
        ev(6'h00, 6'h3f, 1'b1, 32'hffff_ffff);
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("return vs write", 32'h0, got)
        // Entry beats a same-cycle return
        ev(6'h3f, 6'h3f, 1'b0, 32'h0000_0000);
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("enter vs return", handler_state_pkg::active_mask, got)
        ev(6'h00, 6'h3f, 1'b0, 32'h0000_0000);
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("return all", 32'h0, got)
        `CHK("active none", 6'h00, active)
        // Mid-run reset clears flags that software set
        wr_reg(handler_state_pkg::state_reg_offset, 32'hffff_ffff);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(handler_state_pkg::state_reg_offset, got);
        `CHK("mid reset", handler_state_pkg::state_reg_reset, got)
        `CHK("mid reset active", 6'h00, active)
        test_done();
    end
endmodule : handler_state_tb_top
`default_nettype wire
